/* File: core/nrps_host.sv */
// Host-side NAND command sequencer with its read-data FIFO.
`timescale 1ns/10ps

module nrps_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Filling side.
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Draining side.
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_q;
	logic [AW:0] rp_q;

	// One spare pointer bit tells full from empty; DEPTH must be a power of two.
	assign in_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
	assign out_valid = (wp_q != rp_q);
	assign out_data = mem[rp_q[AW-1:0]];

	// Storage has no reset; only the pointers decide what is valid.
	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[wp_q[AW-1:0]] <= in_data;
		end
	end

	// Pointer updates.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wp_q <= wp_q + (AW + 1)'(1);
			end
			if (out_valid && out_ready) begin
				rp_q <= rp_q + (AW + 1)'(1);
			end
		end
	end
endmodule

// How it works
// [RQ1] Page read: opcode 00h, five address cycles, confirm 30h.
// [RQ2] First read after power-up may skip the 00h opcode.
// [RQ3] After ready, read strobes return bytes from start column up to 4351.
// [RQ4] Cached reads restart when the block address would change.
// [RQ5] Cached read opcode 31h loads next page while current one shifts out.
// [RQ6] After initial read, 31h copies buffer to cache; device busy meanwhile.
// [RQ7] Later 31h waits for the pending load, then copies; busy varies.
// [RQ8] Opcode 3Fh copies last page without a new load.
// [RQ9] Dual-district cached reads use their own sequence, restarted per block; the host refuses any cached read after a dual read.
// [RQ10] Both districts of a dual read share the low six page bits.
// [RQ11] Dual read transfer starts on confirm 30h; device busy throughout.
// [RQ12] Even blocks are district zero, odd blocks district one, per half.
// [RQ13] Paired blocks must both lie in the same half of the range.
// [RQ14] At most one block per district in a dual read.
// [RQ15] Each district address follows its own 60h; 30h closes the pair.
// [RQ16] Write protect stays high for the whole dual read.
// [RQ17] Program confirm 10h after address and data starts programming.
// [RQ18] Opcode 85h takes two column cycles; following data loads there.
// [RQ19] Column change may repeat any number of times before 10h.
// [RQ20] Each read strobe advances the column by one.
// [RQ21] Full address is two column then three page bytes.
// [RQ22] Ready/busy stays low during transfers, high when done.
// [RQ23] Host waits for ready before read strobes after a read opcode.
// [RQ24] Device ignores strobes while busy, so host issues none then.
module nrps_host import nrps_pkg::*; #(
	parameter int WB_CYCLES = WB_CYC,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset_n,
	// Request port.
	input wire nrps_req_type req,
	input wire logic req_valid,
	output logic req_ready,
	output logic done,
	output logic refused,
	// Program data stream.
	input wire logic [7:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	// Read data stream.
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready,
	// Write protect request.
	input wire logic protect,
	// Flash pins.
	output nrps_pins_type pins,
	input wire logic [7:0] io_in,
	input wire logic ready_busy_n
);
	typedef enum {S_IDLE, S_CMD1, S_ADDR1, S_CMD2, S_ADDR2, S_DIN, S_CMD3, S_WB, S_RDY, S_DOUT} nrps_state_type;

	nrps_state_type state_q;
	nrps_req_type req_q;
	nrps_pins_type pins_d, pins_q;
	logic [7:0] tmr_q;
	logic [12:0] n_q;
	logic [39:0] addr_q;
	logic [5:0] ld_page_q;
	logic first_q, cache_ok_q, done_q, refused_q;
	logic rb_s1_q, rb_s2_q, rb_s3_q, rb_q;
	logic fire, bad, wr_st, go, step_end, cap, f_in_ready;
	logic [13:0] span;

	// Full five-cycle address: two column bytes then three row bytes.
	function automatic logic [39:0] addr_full(input logic [12:0] col, input logic [17:0] row);
		return {6'h00, row, 3'h0, col};
	endfunction

	// Row-only address used by the dual-district setup.
	function automatic logic [39:0] addr_row(input logic [17:0] row);
		return {22'h00_0000, row};
	endfunction

	// Legal district pair: same page, same half, different district.
	function automatic logic pair_ok(input logic [17:0] a, input logic [17:0] b);
		return (a[PAGE_BITS-1:0] == b[PAGE_BITS-1:0]) && (a[HALF_BIT] == b[HALF_BIT]) && (a[DIST_BIT] != b[DIST_BIT]);
	endfunction

	// Ready/busy is asynchronous; a change counts once the last two stages agree.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rb_s1_q <= 1'b0;
			rb_s2_q <= 1'b0;
			rb_s3_q <= 1'b0;
			rb_q <= 1'b0;
		end else begin
			rb_s1_q <= ready_busy_n;
			rb_s2_q <= rb_s1_q;
			rb_s3_q <= rb_s2_q;
			if (rb_s2_q == rb_s3_q) begin
				rb_q <= rb_s3_q;
			end
		end
	end

	// Request checks; refused requests never reach the pins.
	always_comb begin
		span = ((req.op == OP_READ) ? {1'b0, req.col} : 14'h0000) + {1'b0, req.count};
		bad = 1'b0;
		// [RQ10] [RQ12] [RQ13] [RQ14] district pair checks
		if (req.op == OP_DUAL_READ && !pair_ok(req.row, req.row2)) begin
			bad = 1'b1;
		end
		// [RQ4] block change restart
		if ((req.op == OP_CACHE || req.op == OP_CACHE_LAST) && !cache_ok_q) begin
			bad = 1'b1;
		end
		if (req.op == OP_CACHE && ld_page_q == LAST_PAGE) begin
			bad = 1'b1;
		end
		// [RQ3] page end limit
		if ((req.op == OP_READ || req.op == OP_CACHE || req.op == OP_CACHE_LAST) && span > PAGE_SIZE) begin
			bad = 1'b1;
		end
	end

	assign req_ready = (state_q == S_IDLE);
	assign fire = req_valid && req_ready;
	assign wr_st = (state_q inside {S_CMD1, S_ADDR1, S_CMD2, S_ADDR2, S_DIN, S_CMD3});

	// A strobe starts only when data or FIFO room is there, so back-pressure stalls the pins.
	always_comb begin
		go = 1'b1;
		if (tmr_q == 8'h00 && state_q == S_DIN) begin
			go = wr_valid && (n_q != 13'h0000);
		end else if (tmr_q == 8'h00 && state_q == S_DOUT) begin
			go = f_in_ready && (n_q != 13'h0000);
		end
		step_end = go && (state_q == S_DOUT ? tmr_q == RD_LEN_CYC - 8'h01 : wr_st && tmr_q == WE_LEN_CYC - 8'h01);
		// [RQ20] one byte per strobe
		cap = (state_q == S_DOUT) && go && (tmr_q == RD_LOW_CYC - 8'h01);
	end
	assign wr_ready = (state_q == S_DIN) && (tmr_q == 8'h00) && (n_q != 13'h0000);

	// Strobe and wait timer.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tmr_q <= 8'h00;
		end else if (step_end || state_q == S_IDLE || state_q == S_RDY) begin
			tmr_q <= 8'h00;
		end else if ((wr_st || state_q == S_DOUT) && go || state_q == S_WB) begin
			tmr_q <= tmr_q + 8'h01;
		end
	end

	// Sequencer: command, address, data and busy phases per operation.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= S_IDLE;
			req_q <= '0;
			n_q <= 13'h0000;
			addr_q <= '0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (fire && !bad) begin
						req_q <= req;
						addr_q <= (req.op == OP_DUAL_READ) ? addr_row(req.row) : addr_full(req.col, req.row);
						n_q <= (req.op == OP_DUAL_READ) ? ADDR_ROW_N : (req.op == OP_PROG_COL) ? ADDR_COL_N : ADDR_FULL_N;
						case (req.op)
							// [RQ2] skip held opcode
							OP_READ: state_q <= first_q ? S_ADDR1 : S_CMD1;
							OP_CACHE, OP_CACHE_LAST: begin
								state_q <= S_CMD3;
								n_q <= req.count;
							end
							OP_PROG_CONFIRM: state_q <= S_CMD3;
							default: state_q <= S_CMD1;
						endcase
					end
				end
				S_CMD1: if (step_end) state_q <= S_ADDR1;
				S_ADDR1, S_ADDR2: begin
					if (step_end) begin
						addr_q <= addr_q >> 8;
						n_q <= n_q - 13'h0001;
						if (n_q == 13'h0001) begin
							if (state_q == S_ADDR1 && req_q.op == OP_DUAL_READ) begin
								state_q <= S_CMD2;
							end else if (req_q.op == OP_PROG_LOAD || req_q.op == OP_PROG_COL) begin
								// [RQ18] [RQ19] data at new column
								state_q <= S_DIN;
								n_q <= req_q.count;
							end else begin
								state_q <= S_CMD3;
							end
						end
					end
				end
				S_CMD2: begin
					// [RQ15] second district address
					if (step_end) begin
						state_q <= S_ADDR2;
						addr_q <= addr_row(req_q.row2);
						n_q <= ADDR_ROW_N;
					end
				end
				S_DIN: begin
					if (n_q == 13'h0000) begin
						state_q <= S_IDLE;
					end else if (step_end) begin
						n_q <= n_q - 13'h0001;
						if (n_q == 13'h0001) state_q <= S_IDLE;
					end
				end
				S_CMD3: begin
					if (step_end) begin
						state_q <= S_WB;
						if (req_q.op == OP_READ || req_q.op == OP_DUAL_READ) n_q <= req_q.count;
					end
				end
				S_WB: if (tmr_q == 8'(WB_CYCLES - 1)) state_q <= S_RDY;
				S_RDY: begin
					// [RQ22] [RQ23] wait for ready
					if (rb_q) state_q <= (req_q.op == OP_PROG_CONFIRM) ? S_IDLE : S_DOUT;
				end
				S_DOUT: begin
					if (n_q == 13'h0000) begin
						state_q <= S_IDLE;
					end else if (step_end) begin
						n_q <= n_q - 13'h0001;
						if (n_q == 13'h0001) state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Cache-read bookkeeping: which page the device is loading, and whether chaining is legal.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			first_q <= 1'b1;
			cache_ok_q <= 1'b0;
			ld_page_q <= 6'h00;
		end else if (fire && !bad) begin
			first_q <= 1'b0;
			cache_ok_q <= (req.op == OP_READ) || (req.op == OP_CACHE);
			if (req.op == OP_READ) begin
				ld_page_q <= req.row[PAGE_BITS-1:0];
			end else if (req.op == OP_CACHE) begin
				// [RQ5] [RQ7] next page loads
				ld_page_q <= ld_page_q + 6'h01;
			end
		end
	end

	// Pin values before the output flip-flops.
	always_comb begin
		pins_d = pins_q;
		pins_d.cle = (state_q inside {S_CMD1, S_CMD2, S_CMD3});
		pins_d.ale = (state_q inside {S_ADDR1, S_ADDR2});
		pins_d.ce_n = (state_q == S_IDLE);
		// [RQ24] no strobes while busy
		pins_d.we_n = !(wr_st && go && tmr_q < WE_LOW_CYC);
		pins_d.read_strobe_n = !(state_q == S_DOUT && go && tmr_q < RD_LOW_CYC);
		pins_d.io_oe_n = !wr_st;
		// [RQ16] protect released
		pins_d.wp_n = !protect || (state_q != S_IDLE && req_q.op == OP_DUAL_READ);
		case (state_q)
			S_CMD1: begin
				// [RQ1] [RQ21] setup opcodes
				case (req_q.op)
					OP_DUAL_READ: pins_d.io_out = CMD_DUAL;
					OP_PROG_LOAD: pins_d.io_out = CMD_PROG;
					OP_PROG_COL: pins_d.io_out = CMD_COL;
					default: pins_d.io_out = CMD_READ;
				endcase
			end
			S_CMD2: pins_d.io_out = CMD_DUAL;
			S_CMD3: begin
				// [RQ6] [RQ8] [RQ11] [RQ17] confirm opcodes
				case (req_q.op)
					OP_CACHE: pins_d.io_out = CMD_CACHE;
					OP_CACHE_LAST: pins_d.io_out = CMD_CACHE_LAST;
					OP_PROG_CONFIRM: pins_d.io_out = CMD_PROG_CFM;
					default: pins_d.io_out = CMD_READ_CFM;
				endcase
			end
			S_ADDR1, S_ADDR2: pins_d.io_out = addr_q[7:0];
			S_DIN: if (tmr_q == 8'h00) pins_d.io_out = wr_data;
			default: pins_d.io_out = pins_q.io_out;
		endcase
	end

	// Pins leave from flip-flops so strobes never glitch.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pins_q <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, read_strobe_n: 1'b1,
				wp_n: 1'b0, io_out: 8'h00, io_oe_n: 1'b1};
			done_q <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			pins_q <= pins_d;
			done_q <= (state_q != S_IDLE) && (state_q != S_CMD1 || req_q.op != OP_READ) && (
				(state_q == S_RDY && rb_q && req_q.op == OP_PROG_CONFIRM) ||
				((state_q == S_DIN || state_q == S_DOUT) && (n_q == 13'h0000 || (step_end && n_q == 13'h0001))));
			refused_q <= fire && bad;
		end
	end
	assign pins = pins_q;
	assign done = done_q;
	assign refused = refused_q;

	// Read bytes wait in the FIFO until the user drains them.
	nrps_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(ref_clk),
		.reset_n(reset_n),
		.in_data(io_in),
		.in_valid(cap),
		.in_ready(f_in_ready),
		.out_data(rd_data),
		.out_valid(rd_valid),
		.out_ready(rd_ready)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	property p_read_cmd;
		fire && !bad && req.op == OP_READ && !first_q |-> ##2 (pins_q.cle && pins_q.io_out == CMD_READ);
	endproperty
	a_read_cmd: assert property (p_read_cmd) else $error("Read did not open with its opcode."); // [RQ1]
	property p_first_read;
		fire && !bad && req.op == OP_READ && first_q |-> ##2 (pins_q.ale && !pins_q.cle);
	endproperty
	a_first_read: assert property (p_first_read) else $error("First read did not go straight to address."); // [RQ2]
	property p_pair;
		fire && req.op == OP_DUAL_READ && !pair_ok(req.row, req.row2) |=> refused && state_q == S_IDLE;
	endproperty
	a_pair: assert property (p_pair) else $error("Bad district pair was not refused."); // [RQ13]
	property p_block_end;
		fire && req.op == OP_CACHE && ld_page_q == LAST_PAGE |=> refused;
	endproperty
	a_block_end: assert property (p_block_end) else $error("Cached read crossed a block."); // [RQ4]
	property p_quiet;
		state_q == S_WB || state_q == S_RDY |=> pins_q.we_n && pins_q.read_strobe_n;
	endproperty
	a_quiet: assert property (p_quiet) else $error("Strobe while waiting for ready."); // [RQ24]
	property p_hold_busy;
		state_q == S_RDY && !rb_q |=> state_q == S_RDY;
	endproperty
	a_hold_busy: assert property (p_hold_busy) else $error("Left busy wait before ready."); // [RQ23]
	property p_dual_cfm;
		state_q == S_CMD3 && req_q.op == OP_DUAL_READ |=> pins_q.io_out == CMD_READ_CFM && pins_q.cle;
	endproperty
	a_dual_cfm: assert property (p_dual_cfm) else $error("Dual read confirm opcode wrong."); // [RQ11]
	property p_wp;
		state_q != S_IDLE && req_q.op == OP_DUAL_READ |=> pins_q.wp_n;
	endproperty
	a_wp: assert property (p_wp) else $error("Write protect low during dual read."); // [RQ16]
	property p_prog_cfm;
		state_q == S_CMD3 && req_q.op == OP_PROG_CONFIRM |=> pins_q.io_out == CMD_PROG_CFM;
	endproperty
	a_prog_cfm: assert property (p_prog_cfm) else $error("Program confirm opcode wrong."); // [RQ17]
	property p_cap;
		cap |-> ##3 (n_q == $past(n_q) - 13'h0001 || state_q == S_IDLE);
	endproperty
	a_cap: assert property (p_cap) else $error("Captured byte did not advance the count."); // [RQ20]
	property p_col_len;
		state_q == S_CMD1 && req_q.op == OP_PROG_COL && step_end |=> state_q == S_ADDR1 && n_q == ADDR_COL_N;
	endproperty
	a_col_len: assert property (p_col_len) else $error("Column change used too many address cycles."); // [RQ18]

	c_read: cover property (req_q.op == OP_READ && done);
	c_cache_last: cover property (state_q == S_RDY && req_q.op == OP_CACHE_LAST && rb_q);
	c_prog: cover property (state_q == S_RDY && req_q.op == OP_PROG_CONFIRM && rb_q);
endmodule

/* File: core/nrps_pkg.sv */
// Shared constants and types for the NAND read/program host sequencer.
package nrps_pkg;

	// Clock period and pin timing, in ns.
	localparam int CLK_NS = 5;
	localparam int WE_LOW_NS = 15;
	localparam int WE_HIGH_NS = 10;
	localparam int RD_LOW_NS = 25;
	localparam int RD_HIGH_NS = 10;
	localparam int WB_NS = 100;

	// Least times round up to whole cycles.
	localparam logic [7:0] WE_LOW_CYC = 8'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] WE_LEN_CYC = 8'(WE_LOW_CYC + (WE_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RD_LOW_CYC = 8'((RD_LOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RD_LEN_CYC = 8'(RD_LOW_CYC + (RD_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam int WB_CYC = (WB_NS + CLK_NS - 1) / CLK_NS;

	// Opcodes placed on the I/O port in command cycles.
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_READ_CFM = 8'h30;
	localparam logic [7:0] CMD_CACHE = 8'h31;
	localparam logic [7:0] CMD_CACHE_LAST = 8'h3f;
	localparam logic [7:0] CMD_DUAL = 8'h60;
	localparam logic [7:0] CMD_PROG = 8'h80;
	localparam logic [7:0] CMD_COL = 8'h85;
	localparam logic [7:0] CMD_PROG_CFM = 8'h10;

	// Address layout: page bits, district bit and half bit of the row.
	localparam int PAGE_BITS = 6;
	localparam int DIST_BIT = 6;
	localparam int HALF_BIT = 17;
	localparam logic [5:0] LAST_PAGE = 6'h3f;
	localparam logic [13:0] PAGE_SIZE = 14'h1100;
	localparam logic [12:0] ADDR_FULL_N = 13'h0005;
	localparam logic [12:0] ADDR_ROW_N = 13'h0003;
	localparam logic [12:0] ADDR_COL_N = 13'h0002;

	typedef enum logic [2:0] {
		OP_READ,
		OP_CACHE,
		OP_CACHE_LAST,
		OP_DUAL_READ,
		OP_PROG_LOAD,
		OP_PROG_COL,
		OP_PROG_CONFIRM
	} nrps_op_type;

	typedef struct packed {
		nrps_op_type op;
		logic [12:0] col;
		logic [17:0] row;
		logic [17:0] row2;
		logic [12:0] count;
	} nrps_req_type;

	typedef struct packed {
		logic cle;
		logic ale;
		logic ce_n;
		logic we_n;
		logic read_strobe_n;
		logic wp_n;
		logic [7:0] io_out;
		logic io_oe_n;
	} nrps_pins_type;

endpackage

/* File: bench/nrps_flash_model.sv */
// Behavioural NAND flash device that answers the host sequencer's pins.
`timescale 1ns/10ps
module nrps_flash_model import nrps_pkg::*; #(
	parameter int BUSY_NS = 200
) (
	// Host side pins.
	input wire nrps_pins_type pins,
	// Device answers.
	output logic [7:0] io_in,
	output logic ready_busy_n
);
	logic [7:0] last;
	logic [7:0] mem [16];
	logic [12:0] col_q;
	logic [17:0] row_q;
	logic [17:0] buf_row;
	logic [17:0] cache_row;
	logic [17:0] prog_row;
	logic dual_q;
	int k;
	int rd_strobe_cnt;
	int busy_hits;
	int wp_low_dual;
	int cmd_cnt [256];

	// Data depends on page bits and column only, so both districts agree.
	function automatic logic [7:0] pat(input logic [17:0] r, input logic [12:0] c);
		return c[7:0] ^ {r[5:0], 2'b01};
	endfunction

	task automatic go_busy();
		ready_busy_n = 1'b0;
		ready_busy_n <= #(BUSY_NS) 1'b1;
	endtask

	initial begin
		k = 0;
		col_q = 13'h0000;
		row_q = '0;
		buf_row = '0;
		cache_row = '0;
		dual_q = 1'b0;
		last = 8'h00;
		io_in = 8'h00;
		ready_busy_n = 1'b1;
	end

	task automatic take_cmd(input logic [7:0] c);
		cmd_cnt[c]++;
		k = 0;
		case (c)
			8'h60: begin
				k = 2;
				col_q = 13'h0000;
				dual_q = 1'b1;
				wp_low_dual += int'(!pins.wp_n);
			end
			8'h30: begin
				buf_row = row_q;
				cache_row = row_q;
				go_busy();
			end
			8'h31: begin
				cache_row = buf_row;
				buf_row = buf_row + 18'h0_0001;
				col_q = 13'h0000;
				go_busy();
			end
			8'h3f: begin
				cache_row = buf_row;
				col_q = 13'h0000;
				go_busy();
			end
			8'h10: begin
				prog_row = row_q;
				go_busy();
			end
			8'h00, 8'h80: begin
				dual_q = 1'b0;
			end
			default: begin
			end
		endcase
	endtask

	task automatic take_addr(input logic [7:0] b);
		case (k)
			0: col_q[7:0] = b;
			1: col_q[12:8] = b[4:0];
			2: row_q[7:0] = b;
			3: row_q[15:8] = b;
			default: row_q[17:16] = b[1:0];
		endcase
		k++;
	endtask

	always @(posedge pins.we_n) begin
		if (!pins.ce_n && !ready_busy_n) begin
			busy_hits++;
		end else if (!pins.ce_n && pins.cle) begin
			take_cmd(pins.io_out);
		end else if (!pins.ce_n && pins.ale) begin
			take_addr(pins.io_out);
		end else if (!pins.ce_n) begin
			mem[col_q[3:0]] = pins.io_out;
			col_q = col_q + 13'h0001;
		end
	end

	always @(negedge pins.read_strobe_n) begin
		if (!pins.ce_n && !ready_busy_n) begin
			busy_hits++;
		end else if (!pins.ce_n) begin
			wp_low_dual += int'(dual_q && !pins.wp_n);
			last = pat(cache_row, col_q);
			io_in = last;
			col_q = col_q + 13'h0001;
			rd_strobe_cnt++;
		end
	end

	// A released bus shows the inverse of the last byte, so stale data cannot pass.
	always @(posedge pins.read_strobe_n) begin
		io_in = ~last;
	end
endmodule

/* File: bench/nrps_host_tb.sv */
// Self-checking bench for the NAND host sequencer against a behavioural flash.
`timescale 1ns/10ps
module nrps_host_tb import nrps_pkg::*;;
	logic ref_clk;
	logic reset_n;
	nrps_req_type req;
	logic req_valid, req_ready, done, refused;
	logic [7:0] wr_data;
	logic wr_valid, wr_ready;
	logic [7:0] rd_data;
	logic rd_valid, rd_ready, protect;
	nrps_pins_type pins;
	logic [7:0] io_in;
	logic ready_busy_n;
	logic [7:0] wq [$];
	logic [7:0] rq [$];
	int error_cnt;
	int checks;

	nrps_host #(.WB_CYCLES(20), .FIFO_DEPTH(8)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .req(req),
		.req_valid(req_valid), .req_ready(req_ready), .done(done), .refused(refused), .wr_data(wr_data),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.protect(protect), .pins(pins), .io_in(io_in), .ready_busy_n(ready_busy_n));
	nrps_flash_model #(.BUSY_NS(200)) fm (.pins(pins), .io_in(io_in), .ready_busy_n(ready_busy_n));

	// Free-running 200 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Bytes leave or join the queues at the edge that moves them.
	always @(posedge ref_clk) begin
		if (wr_valid && wr_ready) begin
			void'(wq.pop_front());
		end
		if (rd_valid && rd_ready) begin
			rq.push_back(rd_data);
		end
	end

	// Program bytes are presented on the falling edge, clear of sampling.
	always @(negedge ref_clk) begin
		wr_valid <= (wq.size() > 0);
		wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
	end

	function automatic logic [7:0] pat(input logic [17:0] r, input logic [12:0] c);
		return c[7:0] ^ {r[5:0], 2'b01};
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_cnt(input int got, input int exp);
		checks++;
		if (got != exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask

	// One request through the port; the outcome pulse is looked for every cycle.
	task automatic run(input nrps_op_type op, input logic [12:0] col, input logic [17:0] row,
		input logic [17:0] row2, input logic [12:0] n, input logic exp_ref);
		int i;
		@(negedge ref_clk);
		req = '{op, col, row, row2, n};
		req_valid = 1'b1;
		for (i = 0; req_ready !== 1'b1 && i < 1000; i++) begin
			@(negedge ref_clk);
		end
		cmp(req_ready, 1'b1);
		@(negedge ref_clk);
		req_valid = 1'b0;
		for (i = 0; done !== 1'b1 && refused !== 1'b1 && i < 20000; i++) begin
			@(negedge ref_clk);
		end
		cmp(done || refused, 1'b1);
		cmp(refused, exp_ref);
		repeat (12) @(negedge ref_clk);
	endtask

	task automatic chk_rd(input logic [17:0] r, input logic [12:0] c, input int n);
		cmp_cnt(rq.size(), n);
		for (int i = 0; i < n && i < rq.size(); i++) begin
			cmp(rq[i], pat(r, c + 13'(i)));
		end
		rq.delete();
	endtask

	task automatic t_power_read();
		run(OP_READ, 13'h10fe, 18'h2_0456, '0, 13'h0002, 1'b0);
		cmp_cnt(fm.cmd_cnt[CMD_READ], 0);
		cmp(fm.row_q, 18'h2_0456);
		chk_rd(18'h2_0456, 13'h10fe, 2);
	endtask

	task automatic t_plain_read();
		run(OP_READ, 13'h10ff, 18'h0_0123, '0, 13'h0002, 1'b1);
		run(OP_READ, 13'h0005, 18'h0_0123, '0, 13'h0003, 1'b0);
		cmp_cnt(fm.cmd_cnt[CMD_READ], 1);
		chk_rd(18'h0_0123, 13'h0005, 3);
	endtask

	task automatic t_cache();
		run(OP_READ, '0, 18'h0_0100, '0, 13'h0002, 1'b0);
		chk_rd(18'h0_0100, '0, 2);
		run(OP_CACHE, '0, '0, '0, 13'h0002, 1'b0);
		chk_rd(18'h0_0100, '0, 2);
		run(OP_CACHE, '0, '0, '0, 13'h0002, 1'b0);
		chk_rd(18'h0_0101, '0, 2);
		run(OP_CACHE_LAST, '0, '0, '0, 13'h0002, 1'b0);
		chk_rd(18'h0_0102, '0, 2);
		run(OP_CACHE, '0, '0, '0, 13'h0002, 1'b1);
		run(OP_READ, '0, 18'h0_013f, '0, 13'h0001, 1'b0);
		rq.delete();
		run(OP_CACHE, '0, '0, '0, 13'h0002, 1'b1);
	endtask

	// The reader stalls until the FIFO is full, then drains it.
	task automatic t_fifo();
		int base;
		base = fm.rd_strobe_cnt;
		rd_ready = 1'b0;
		fork
			begin
				repeat (400) @(negedge ref_clk);
				cmp_cnt(fm.rd_strobe_cnt - base, 8);
				rd_ready = 1'b1;
			end
		join_none
		run(OP_READ, 13'h0100, 18'h0_0200, '0, 13'h000c, 1'b0);
		chk_rd(18'h0_0200, 13'h0100, 12);
	endtask

	task automatic t_dual();
		logic [17:0] bad [3];
		int c60;
		bad = '{18'h0_0085, 18'h2_00c5, 18'h0_00c6};
		c60 = fm.cmd_cnt[CMD_DUAL];
		protect = 1'b1;
		repeat (3) @(negedge ref_clk);
		cmp(pins.wp_n, 1'b0);
		foreach (bad[i]) begin
			run(OP_DUAL_READ, '0, 18'h0_0005, bad[i], 13'h0002, 1'b1);
		end
		run(OP_DUAL_READ, '0, 18'h0_00c5, 18'h0_0005, 13'h0002, 1'b0);
		cmp_cnt(fm.cmd_cnt[CMD_DUAL] - c60, 2);
		cmp_cnt(fm.wp_low_dual, 0);
		chk_rd(18'h0_0005, '0, 2);
		// A cached read may not chain onto a dual read; the host refuses it.
		run(OP_CACHE, '0, '0, '0, 13'h0002, 1'b1);
		protect = 1'b0;
	endtask

	task automatic t_prog();
		int c85;
		c85 = fm.cmd_cnt[CMD_COL];
		wq = '{8'ha0, 8'ha1, 8'ha2, 8'hb0, 8'hb1, 8'hc0};
		run(OP_PROG_LOAD, 13'h0004, 18'h0_0777, '0, 13'h0003, 1'b0);
		run(OP_PROG_COL, 13'h000a, '0, '0, 13'h0002, 1'b0);
		run(OP_PROG_COL, 13'h0000, '0, '0, 13'h0001, 1'b0);
		run(OP_PROG_CONFIRM, '0, '0, '0, '0, 1'b0);
		cmp_cnt(fm.cmd_cnt[CMD_COL] - c85, 2);
		cmp(fm.mem[6], 8'ha2);
		cmp(fm.mem[11], 8'hb1);
		cmp(fm.mem[0], 8'hc0);
		cmp(fm.prog_row, 18'h0_0777);
		cmp(ready_busy_n, 1'b1);
		run(OP_CACHE, '0, '0, '0, 13'h0002, 1'b1);
	endtask

	task automatic end_of_test();
		$display("checks %0d, errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Main sequence: reset, then one task per scenario.
	initial begin
		error_cnt = 0;
		checks = 0;
		reset_n = 1'b0;
		req = '0;
		req_valid = 1'b0;
		rd_ready = 1'b1;
		protect = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		cmp(pins.ce_n, 1'b1);
		cmp(pins.io_oe_n, 1'b1);
		@(negedge ref_clk);
		reset_n = 1'b1;
		t_power_read();
		t_plain_read();
		t_cache();
		t_fifo();
		t_dual();
		t_prog();
		cmp_cnt(fm.busy_hits, 0);
		end_of_test();
	end

	// The run needs a few microseconds; this bound only trips on a hang.
	initial begin
		#200000;
		error_cnt++;
		end_of_test();
	end
endmodule
